// ---- verilog/cis_core_irq_seq.sv ----
// core interrupt sequencer: flags, enables, entry, return, wake
// ------------------------------------------------------------
// ------------------------------------------------------------
//
// Chosen here: the address map and the AXI4-Lite interface to the registers.
`default_nettype none
module cis_core_irq_seq
    import cis_pkg::*;
(
    input wire logic MCLK_IN,
    input wire logic RST_N_IN,
    input wire logic [7:0] S_AXI_AWADDR_IN,
    input wire logic S_AXI_AWVALID_IN,
    output logic S_AXI_AWREADY_OUT,
    input wire logic [31:0] S_AXI_WDATA_IN,
    input wire logic [3:0] S_AXI_WSTRB_IN,
    input wire logic S_AXI_WVALID_IN,
    output logic S_AXI_WREADY_OUT,
    output logic [1:0] S_AXI_BRESP_OUT,
    output logic S_AXI_BVALID_OUT,
    input wire logic S_AXI_BREADY_IN,
    input wire logic [7:0] S_AXI_ARADDR_IN,
    input wire logic S_AXI_ARVALID_IN,
    output logic S_AXI_ARREADY_OUT,
    output logic [31:0] S_AXI_RDATA_OUT,
    output logic [1:0] S_AXI_RRESP_OUT,
    output logic S_AXI_RVALID_OUT,
    input wire logic S_AXI_RREADY_IN,
    input wire logic CORE_TMR_OVF_IN,
    input wire logic EXT_PIN_IN,
    input wire logic [7:0] PIN_CHANGE_FLAGS_IN,
    input wire logic [31:0] PERIPH_EVENT_IN,
    input wire logic CORE_INSTR_END_IN,
    input wire logic CORE_SLEEP_IN,
    input wire logic CORE_RETURN_FROM_SERVICE_INSTR_IN,
    input wire logic [7:0] CORE_W_IN,
    input wire logic [7:0] CORE_STATUS_IN,
    input wire logic [7:0] CORE_BSR_IN,
    input wire logic [15:0] CORE_FSR0_IN,
    input wire logic [15:0] CORE_FSR1_IN,
    input wire logic [7:0] CORE_PCLATH_IN,
    input wire logic [14:0] CORE_PC_IN,
    output logic INSTR_CYCLE_OUT,
    output logic FLUSH_OUT,
    output logic PUSH_OUT,
    output logic [14:0] PUSH_ADDR_OUT,
    output logic LOAD_PC_OUT,
    output logic [14:0] LOAD_PC_ADDR_OUT,
    output logic POP_OUT,
    output logic RESTORE_OUT,
    output logic [7:0] SHADOW_W_OUT,
    output logic [7:0] SHADOW_STATUS_OUT,
    output logic [7:0] SHADOW_BSR_OUT,
    output logic [15:0] SHADOW_FSR0_OUT,
    output logic [15:0] SHADOW_FSR1_OUT,
    output logic [7:0] SHADOW_PCLATH_OUT,
    output logic WAKE_OUT,
    output logic GIE_OUT,
    output logic IRQ_OUT
);
    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic [1:0] qphase_q;
    logic cyc_en;
    logic [7:0] ctrl_q;
    logic [31:0] pflag_q, pen_q;
    logic edge_sel_q, ext_pin_q, ext_edge;
    logic [7:0] sh_w_q, sh_status_q, sh_bsr_q, sh_pclath_q;
    logic [15:0] sh_fsr0_q, sh_fsr1_q;
    logic [EVT_W-1:0] evt_stat_q, evt_mask_q, evt_set;
    cis_state_t state_q;
    logic sleep_prev_q, post_wake_q;
    logic core_pend, periph_pend, irq_req, wake_req, entry;
    logic aw_hold_q, w_hold_q;
    logic [7:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic wr_fire, wr_lo, wr_hi;
    logic [7:0] wr_addr, wr_byte;
    logic [31:0] rd_data;
    logic rd_ok, wr_ok;
    logic [1:0] pidx_w;
    // ------------------------------------------------------------
    // instruction cycle enable, four clocks per cycle
    // ------------------------------------------------------------
    always_ff @(posedge MCLK_IN) begin
        if (!RST_N_IN) begin
            qphase_q <= 2'h0;
        end else begin
            qphase_q <= qphase_q + 2'h1;
        end
    end
    assign cyc_en = (qphase_q == QPHASE_LAST);
    // ------------------------------------------------------------
    // request forming
    // ------------------------------------------------------------
    // summary flag is the live or of the pin change flags, never stored
    logic pchg_sum;
    assign pchg_sum = |PIN_CHANGE_FLAGS_IN;
    assign core_pend = (ctrl_q[CTL_TMR_IE] & ctrl_q[CTL_TMR_IF])
        | (ctrl_q[CTL_EXT_IE] & ctrl_q[CTL_EXT_IF])
        | (ctrl_q[CTL_PCHG_IE] & pchg_sum);
    assign periph_pend = |(pflag_q & pen_q);
    assign wake_req = core_pend | (ctrl_q[CTL_PERIPH_GROUP_IRQ_ENABLE] & periph_pend);
    assign irq_req = ctrl_q[CTL_GIE] & wake_req;
    // sleep and the instruction after wake both block entry
    assign entry = cyc_en && (state_q == ST_RUN) && irq_req && CORE_INSTR_END_IN
        && !CORE_SLEEP_IN && !post_wake_q;
    // ------------------------------------------------------------
    // external pin edge detect
    // ------------------------------------------------------------
    always_ff @(posedge MCLK_IN) begin
        if (!RST_N_IN) begin
            ext_pin_q <= 1'b0;
        end else begin
            ext_pin_q <= EXT_PIN_IN;
        end
    end
    assign ext_edge = edge_sel_q ? (EXT_PIN_IN & ~ext_pin_q)
        : (~EXT_PIN_IN & ext_pin_q);
    // ------------------------------------------------------------
    // axi4-lite write channel
    // ------------------------------------------------------------
    assign S_AXI_AWREADY_OUT = !aw_hold_q && !S_AXI_BVALID_OUT;
    assign S_AXI_WREADY_OUT = !w_hold_q && !S_AXI_BVALID_OUT;
    always_ff @(posedge MCLK_IN) begin
        if (!RST_N_IN) begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
        end else begin
            if (S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT) begin
                aw_hold_q <= 1'b1;
                aw_addr_q <= S_AXI_AWADDR_IN;
            end else if (wr_fire) begin
                aw_hold_q <= 1'b0;
            end
            if (S_AXI_WVALID_IN && S_AXI_WREADY_OUT) begin
                w_hold_q <= 1'b1;
                w_data_q <= S_AXI_WDATA_IN;
                w_strb_q <= S_AXI_WSTRB_IN;
            end else if (wr_fire) begin
                w_hold_q <= 1'b0;
            end
        end
    end
    assign wr_fire = aw_hold_q && w_hold_q;
    assign wr_addr = aw_addr_q;
    assign wr_byte = w_data_q[7:0];
    // refused writes must leave every register untouched
    assign wr_lo = wr_fire && wr_ok && w_strb_q[0];
    assign wr_hi = wr_fire && wr_ok && w_strb_q[1];
    assign pidx_w = 2'(wr_addr[7:2] - 6'h01);
    assign wr_ok = (wr_addr[1:0] == 2'h0) && (wr_addr <= ADDR_IRQ_MASK)
        && (wr_addr != ADDR_SEQ_STAT);
    always_ff @(posedge MCLK_IN) begin
        if (!RST_N_IN) begin
            S_AXI_BVALID_OUT <= 1'b0;
            S_AXI_BRESP_OUT <= RESP_OKAY;
        end else if (wr_fire) begin
            S_AXI_BVALID_OUT <= 1'b1;
            S_AXI_BRESP_OUT <= wr_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (S_AXI_BREADY_IN) begin
            S_AXI_BVALID_OUT <= 1'b0;
        end
    end
    // ------------------------------------------------------------
    // core control register and edge select
    // ------------------------------------------------------------
    always_ff @(posedge MCLK_IN) begin
        if (!RST_N_IN) begin
            ctrl_q <= CTRL_RESET;
            edge_sel_q <= 1'b0;
        end else begin
            if (wr_lo && wr_addr == ADDR_CORE_CTRL) ctrl_q[7:1] <= wr_byte[7:1];
            if (wr_lo && wr_addr == ADDR_OPTION) edge_sel_q <= wr_byte[OPT_EDGE];
            // hardware sets win over a software clear in the same cycle
            if (CORE_TMR_OVF_IN) ctrl_q[CTL_TMR_IF] <= 1'b1;
            if (ext_edge) ctrl_q[CTL_EXT_IF] <= 1'b1;
            if (entry) ctrl_q[CTL_GIE] <= 1'b0;
            else if (CORE_RETURN_FROM_SERVICE_INSTR_IN) ctrl_q[CTL_GIE] <= 1'b1;
            ctrl_q[CTL_PCHG_IF] <= 1'b0;
        end
    end
    assign GIE_OUT = ctrl_q[CTL_GIE];
    // ------------------------------------------------------------
    // peripheral flag and enable registers
    // ------------------------------------------------------------
    always_ff @(posedge MCLK_IN) begin
        if (!RST_N_IN) begin
            pflag_q <= 32'h0000_0000;
            pen_q <= 32'h0000_0000;
        end else begin
            pflag_q <= pflag_q | PERIPH_EVENT_IN;
            // the written byte still takes an event of the same cycle
            if (wr_lo && wr_addr >= ADDR_PFLAG_1 && wr_addr <= ADDR_PFLAG_4) begin
                pflag_q[pidx_w*8 +: 8] <= wr_byte | PERIPH_EVENT_IN[pidx_w*8 +: 8];
            end
            if (wr_lo && wr_addr >= ADDR_PEN_1 && wr_addr <= ADDR_PEN_4) begin
                pen_q[2'(wr_addr[7:2] - 6'h05)*8 +: 8] <= wr_byte;
            end
        end
    end
    // ------------------------------------------------------------
    // shadow registers, saved on entry, writable by software
    // ------------------------------------------------------------
    always_ff @(posedge MCLK_IN) begin
        if (!RST_N_IN) begin
            sh_w_q <= 8'h00;
            sh_status_q <= 8'h00;
            sh_bsr_q <= 8'h00;
            sh_fsr0_q <= 16'h0000;
            sh_fsr1_q <= 16'h0000;
            sh_pclath_q <= 8'h00;
        end else if (entry) begin
            sh_w_q <= CORE_W_IN;
            sh_status_q <= CORE_STATUS_IN & STATUS_SAVE_MASK;
            sh_bsr_q <= CORE_BSR_IN;
            sh_fsr0_q <= CORE_FSR0_IN;
            sh_fsr1_q <= CORE_FSR1_IN;
            sh_pclath_q <= CORE_PCLATH_IN;
        end else begin
            if (wr_lo && wr_addr == ADDR_SH_W) sh_w_q <= wr_byte;
            if (wr_lo && wr_addr == ADDR_SH_STATUS) sh_status_q <= wr_byte;
            if (wr_lo && wr_addr == ADDR_SH_BSR) sh_bsr_q <= wr_byte;
            if (wr_lo && wr_addr == ADDR_SH_PCLATH) sh_pclath_q <= wr_byte;
            if (wr_lo && wr_addr == ADDR_SH_FSR0) sh_fsr0_q[7:0] <= wr_byte;
            if (wr_hi && wr_addr == ADDR_SH_FSR0) sh_fsr0_q[15:8] <= w_data_q[15:8];
            if (wr_lo && wr_addr == ADDR_SH_FSR1) sh_fsr1_q[7:0] <= wr_byte;
            if (wr_hi && wr_addr == ADDR_SH_FSR1) sh_fsr1_q[15:8] <= w_data_q[15:8];
        end
    end
    assign SHADOW_W_OUT = sh_w_q;
    assign SHADOW_STATUS_OUT = sh_status_q;
    assign SHADOW_BSR_OUT = sh_bsr_q;
    assign SHADOW_FSR0_OUT = sh_fsr0_q;
    assign SHADOW_FSR1_OUT = sh_fsr1_q;
    assign SHADOW_PCLATH_OUT = sh_pclath_q;
    // ------------------------------------------------------------
    // entry sequence: flush, one dead cycle, vector
    // ------------------------------------------------------------
    always_ff @(posedge MCLK_IN) begin
        if (!RST_N_IN) begin
            state_q <= ST_RUN;
        end else if (entry) begin
            state_q <= ST_FLUSH;
        end else if (cyc_en) begin
            unique case (state_q)
                ST_RUN: state_q <= ST_RUN;
                ST_FLUSH: state_q <= ST_NOP;
                ST_NOP: state_q <= ST_VECTOR;
                ST_VECTOR: state_q <= ST_RUN;
            endcase
        end
    end
    always_ff @(posedge MCLK_IN) begin
        if (!RST_N_IN) begin
            FLUSH_OUT <= 1'b0;
            PUSH_OUT <= 1'b0;
            PUSH_ADDR_OUT <= 15'h0000;
            LOAD_PC_OUT <= 1'b0;
            LOAD_PC_ADDR_OUT <= 15'h0000;
            POP_OUT <= 1'b0;
            RESTORE_OUT <= 1'b0;
            INSTR_CYCLE_OUT <= 1'b0;
        end else begin
            INSTR_CYCLE_OUT <= cyc_en;
            FLUSH_OUT <= entry;
            PUSH_OUT <= entry;
            if (entry) PUSH_ADDR_OUT <= CORE_PC_IN;
            LOAD_PC_OUT <= cyc_en && (state_q == ST_NOP);
            LOAD_PC_ADDR_OUT <= IRQ_VECTOR;
            POP_OUT <= CORE_RETURN_FROM_SERVICE_INSTR_IN;
            RESTORE_OUT <= CORE_RETURN_FROM_SERVICE_INSTR_IN;
        end
    end
    // ------------------------------------------------------------
    // sleep and wake
    // ------------------------------------------------------------
    // wake ignores the global enable; branching is decided after wake
    always_ff @(posedge MCLK_IN) begin
        if (!RST_N_IN) begin
            sleep_prev_q <= 1'b0;
            post_wake_q <= 1'b0;
            WAKE_OUT <= 1'b0;
        end else begin
            sleep_prev_q <= CORE_SLEEP_IN;
            WAKE_OUT <= CORE_SLEEP_IN && wake_req;
            if (sleep_prev_q && !CORE_SLEEP_IN) post_wake_q <= 1'b1;
            else if (cyc_en && CORE_INSTR_END_IN) post_wake_q <= 1'b0;
        end
    end
    // ------------------------------------------------------------
    // system interrupt: sticky events, mask, write one to clear
    // ------------------------------------------------------------
    assign evt_set = {CORE_SLEEP_IN && wake_req && !WAKE_OUT, CORE_RETURN_FROM_SERVICE_INSTR_IN, entry};
    always_ff @(posedge MCLK_IN) begin
        if (!RST_N_IN) begin
            evt_stat_q <= '0;
            evt_mask_q <= '0;
        end else begin
            evt_stat_q <= (evt_stat_q
                & ~(wr_byte[EVT_W-1:0] & {EVT_W{wr_lo && wr_addr == ADDR_IRQ_STAT}})) | evt_set;
            if (wr_lo && wr_addr == ADDR_IRQ_MASK) evt_mask_q <= wr_byte[EVT_W-1:0];
        end
    end
    assign IRQ_OUT = |(evt_stat_q & evt_mask_q);
    // ------------------------------------------------------------
    // axi4-lite read channel
    // ------------------------------------------------------------
    always_comb begin
        rd_data = 32'h0000_0000;
        rd_ok = 1'b1;
        unique case (S_AXI_ARADDR_IN)
            ADDR_CORE_CTRL: rd_data[7:0] = {ctrl_q[7:1], pchg_sum};
            8'h04, 8'h08, 8'h0c, ADDR_PFLAG_4: begin
                rd_data[7:0] = pflag_q[2'(S_AXI_ARADDR_IN[7:2] - 6'h01)*8 +: 8];
            end
            ADDR_PEN_1, 8'h18, 8'h1c, ADDR_PEN_4: begin
                rd_data[7:0] = pen_q[2'(S_AXI_ARADDR_IN[7:2] - 6'h05)*8 +: 8];
            end
            ADDR_OPTION: rd_data[OPT_EDGE] = edge_sel_q;
            ADDR_SH_W: rd_data[7:0] = sh_w_q;
            ADDR_SH_STATUS: rd_data[7:0] = sh_status_q;
            ADDR_SH_BSR: rd_data[7:0] = sh_bsr_q;
            ADDR_SH_FSR0: rd_data[15:0] = sh_fsr0_q;
            ADDR_SH_FSR1: rd_data[15:0] = sh_fsr1_q;
            ADDR_SH_PCLATH: rd_data[7:0] = sh_pclath_q;
            ADDR_SEQ_STAT: rd_data[4:0] = {irq_req, post_wake_q, CORE_SLEEP_IN, state_q};
            ADDR_IRQ_STAT: rd_data[EVT_W-1:0] = evt_stat_q;
            ADDR_IRQ_MASK: rd_data[EVT_W-1:0] = evt_mask_q;
            default: rd_ok = 1'b0;
        endcase
    end
    assign S_AXI_ARREADY_OUT = !S_AXI_RVALID_OUT;
    always_ff @(posedge MCLK_IN) begin
        if (!RST_N_IN) begin
            S_AXI_RVALID_OUT <= 1'b0;
            S_AXI_RDATA_OUT <= 32'h0000_0000;
            S_AXI_RRESP_OUT <= RESP_OKAY;
        end else if (S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT) begin
            S_AXI_RVALID_OUT <= 1'b1;
            S_AXI_RDATA_OUT <= rd_data;
            S_AXI_RRESP_OUT <= rd_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (S_AXI_RREADY_IN) begin
            S_AXI_RVALID_OUT <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ---- verilog/cis_pkg.sv ----
// constants shared by the core interrupt sequencer
`default_nettype none
package cis_pkg;
    // ------------------------------------------------------------
    // register byte addresses
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CORE_CTRL = 8'h00;
    localparam logic [7:0] ADDR_PFLAG_1 = 8'h04;
    localparam logic [7:0] ADDR_PFLAG_4 = 8'h10;
    localparam logic [7:0] ADDR_PEN_1 = 8'h14;
    localparam logic [7:0] ADDR_PEN_4 = 8'h20;
    localparam logic [7:0] ADDR_OPTION = 8'h24;
    localparam logic [7:0] ADDR_SH_W = 8'h28;
    localparam logic [7:0] ADDR_SH_STATUS = 8'h2c;
    localparam logic [7:0] ADDR_SH_BSR = 8'h30;
    localparam logic [7:0] ADDR_SH_FSR0 = 8'h34;
    localparam logic [7:0] ADDR_SH_FSR1 = 8'h38;
    localparam logic [7:0] ADDR_SH_PCLATH = 8'h3c;
    localparam logic [7:0] ADDR_SEQ_STAT = 8'h40;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h44;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h48;
    // ------------------------------------------------------------
    // core control, option and event register fields
    // ------------------------------------------------------------
    localparam int CTL_GIE = 7;
    localparam int CTL_PERIPH_GROUP_IRQ_ENABLE = 6;
    localparam int CTL_TMR_IE = 5;
    localparam int CTL_EXT_IE = 4;
    localparam int CTL_PCHG_IE = 3;
    localparam int CTL_TMR_IF = 2;
    localparam int CTL_EXT_IF = 1;
    localparam int CTL_PCHG_IF = 0;
    localparam int OPT_EDGE = 0;
    localparam int EVT_ENTRY = 0;
    localparam int EVT_RETURN = 1;
    localparam int EVT_WAKE = 2;
    localparam int EVT_W = 3;
    // ------------------------------------------------------------
    // values
    // ------------------------------------------------------------
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] STATUS_SAVE_MASK = 8'h07;
    localparam logic [14:0] IRQ_VECTOR = 15'h0004;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [1:0] QPHASE_LAST = 2'h3;
    typedef enum logic [1:0] {
        ST_RUN = 2'b00,
        ST_FLUSH = 2'b01,
        ST_NOP = 2'b11,
        ST_VECTOR = 2'b10
    } cis_state_t;
endpackage
`default_nettype wire

// ---- test/cis_seq_chk.sv ----
// port timing checker of the core interrupt sequencer
`default_nettype none
module cis_seq_chk
    import cis_pkg::*;
(
    input wire logic MCLK_IN,
    input wire logic RST_N_IN,
    input wire logic CORE_RETURN_FROM_SERVICE_INSTR_IN,
    input wire logic [7:0] CORE_W_IN,
    input wire logic [7:0] CORE_STATUS_IN,
    input wire logic [14:0] CORE_PC_IN,
    input wire logic INSTR_CYCLE_OUT,
    input wire logic FLUSH_OUT,
    input wire logic PUSH_OUT,
    input wire logic [14:0] PUSH_ADDR_OUT,
    input wire logic LOAD_PC_OUT,
    input wire logic [14:0] LOAD_PC_ADDR_OUT,
    input wire logic POP_OUT,
    input wire logic RESTORE_OUT,
    input wire logic [7:0] SHADOW_W_OUT,
    input wire logic [7:0] SHADOW_STATUS_OUT,
    input wire logic GIE_OUT
);
    default clocking cb @(posedge MCLK_IN); endclocking
    default disable iff (!RST_N_IN);
    rst_clears_a: assert property (disable iff (1'b0) !RST_N_IN |=> !GIE_OUT && !FLUSH_OUT)
        else $error("enable or entry survived reset");
    entry_seq_a: assert property (FLUSH_OUT |-> PUSH_OUT && !GIE_OUT)
        else $error("entry without push or with enable kept");
    vec_time_a: assert property (FLUSH_OUT |-> !LOAD_PC_OUT [*8] ##1 LOAD_PC_OUT)
        else $error("vector load not eight clocks after flush");
    vec_addr_a: assert property (LOAD_PC_OUT |-> LOAD_PC_ADDR_OUT == IRQ_VECTOR)
        else $error("wrong vector address");
    push_pc_a: assert property (FLUSH_OUT |-> PUSH_ADDR_OUT == $past(CORE_PC_IN))
        else $error("pushed address is not the entry pc");
    shadow_save_a: assert property (FLUSH_OUT |-> SHADOW_W_OUT == $past(CORE_W_IN)
        && SHADOW_STATUS_OUT == ($past(CORE_STATUS_IN) & STATUS_SAVE_MASK))
        else $error("context not shadowed at entry");
    gated_entry_a: assert property (!GIE_OUT |=> !FLUSH_OUT)
        else $error("entry with global enable clear");
    ret_enable_a: assert property (CORE_RETURN_FROM_SERVICE_INSTR_IN && !GIE_OUT |=> GIE_OUT)
        else $error("return did not set global enable");
    ret_pop_a: assert property ($rose(CORE_RETURN_FROM_SERVICE_INSTR_IN) |-> ##[1:2] (POP_OUT && RESTORE_OUT))
        else $error("return without pop and restore");
    instr_tick_a: assert property (INSTR_CYCLE_OUT |=> !INSTR_CYCLE_OUT [*3] ##1 INSTR_CYCLE_OUT)
        else $error("instruction tick not every fourth clock");
endmodule
bind cis_core_irq_seq cis_seq_chk chk (.MCLK_IN(MCLK_IN), .RST_N_IN(RST_N_IN),
    .CORE_RETURN_FROM_SERVICE_INSTR_IN(CORE_RETURN_FROM_SERVICE_INSTR_IN), .CORE_W_IN(CORE_W_IN), .CORE_STATUS_IN(CORE_STATUS_IN),
    .CORE_PC_IN(CORE_PC_IN), .INSTR_CYCLE_OUT(INSTR_CYCLE_OUT), .FLUSH_OUT(FLUSH_OUT),
    .PUSH_OUT(PUSH_OUT), .PUSH_ADDR_OUT(PUSH_ADDR_OUT), .LOAD_PC_OUT(LOAD_PC_OUT),
    .LOAD_PC_ADDR_OUT(LOAD_PC_ADDR_OUT), .POP_OUT(POP_OUT), .RESTORE_OUT(RESTORE_OUT),
    .SHADOW_W_OUT(SHADOW_W_OUT), .SHADOW_STATUS_OUT(SHADOW_STATUS_OUT), .GIE_OUT(GIE_OUT));
`default_nettype wire

// ---- test/cis_core_model.sv ----
// core pipeline model: pc, context and boundary strobe
`default_nettype none
module cis_core_model (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic tick_in,
    input wire logic load_in,
    input wire logic [14:0] load_addr_in,
    output logic end_out,
    output logic [14:0] pc_out,
    output logic [7:0] w_out,
    output logic [7:0] st_out
);
    logic [14:0] pc_q;
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            pc_q <= 15'h0100;
        end else if (load_in) begin
            pc_q <= load_addr_in;
        end else if (tick_in) begin
            pc_q <= pc_q + 15'h0001;
        end
    end
    // every cycle is a boundary: single-cycle code only
    assign end_out = 1'b1;
    assign pc_out = pc_q;
    assign w_out = pc_q[7:0] ^ 8'h5a;
    // power bits set so the save mask shows
    assign st_out = 8'hff;
endmodule
`default_nettype wire

// ---- test/tb_top.sv ----
// testbench of the core interrupt sequencer
`default_nettype none
module tb_top import cis_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, rst_n = 0, awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
    logic tmr = 0, pin = 0, sleep = 0, ret = 0;
    logic [7:0] awaddr = 0, araddr = 0, pchg = 0;
    logic [31:0] wdata = 0, pev = 0;
    logic [14:0] p1;
    wire awrdy, wrdy, bvalid, arrdy, rvalid, tick, flush, push, load, pop, rest, wake, global_irq_enable, irq;
    wire iend;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    wire [14:0] pushaddr, loadaddr, pc;
    wire [7:0] w, st;
    int errors = 0, n_tests = 0;
    initial forever #5 clk = ~clk;
    cis_core_irq_seq dut (.MCLK_IN(clk), .RST_N_IN(rst_n), .S_AXI_AWADDR_IN(awaddr),
        .S_AXI_AWVALID_IN(awv), .S_AXI_AWREADY_OUT(awrdy), .S_AXI_WDATA_IN(wdata),
        .S_AXI_WSTRB_IN(4'hf), .S_AXI_WVALID_IN(wv), .S_AXI_WREADY_OUT(wrdy),
        .S_AXI_BRESP_OUT(bresp), .S_AXI_BVALID_OUT(bvalid), .S_AXI_BREADY_IN(bready),
        .S_AXI_ARADDR_IN(araddr), .S_AXI_ARVALID_IN(arv), .S_AXI_ARREADY_OUT(arrdy),
        .S_AXI_RDATA_OUT(rdata), .S_AXI_RRESP_OUT(rresp), .S_AXI_RVALID_OUT(rvalid),
        .S_AXI_RREADY_IN(rready), .CORE_TMR_OVF_IN(tmr), .EXT_PIN_IN(pin),
        .PIN_CHANGE_FLAGS_IN(pchg), .PERIPH_EVENT_IN(pev), .CORE_INSTR_END_IN(iend),
        .CORE_SLEEP_IN(sleep), .CORE_RETURN_FROM_SERVICE_INSTR_IN(ret), .CORE_W_IN(w), .CORE_STATUS_IN(st),
        .CORE_BSR_IN(w), .CORE_FSR0_IN({1'b0, pc}), .CORE_FSR1_IN({pc, 1'b1}),
        .CORE_PCLATH_IN(st), .CORE_PC_IN(pc), .INSTR_CYCLE_OUT(tick), .FLUSH_OUT(flush),
        .PUSH_OUT(push), .PUSH_ADDR_OUT(pushaddr), .LOAD_PC_OUT(load),
        .LOAD_PC_ADDR_OUT(loadaddr), .POP_OUT(pop), .RESTORE_OUT(rest),
        .SHADOW_W_OUT(), .SHADOW_STATUS_OUT(), .SHADOW_BSR_OUT(), .SHADOW_FSR0_OUT(),
        .SHADOW_FSR1_OUT(), .SHADOW_PCLATH_OUT(), .WAKE_OUT(wake), .GIE_OUT(global_irq_enable), .IRQ_OUT(irq));
    cis_core_model core (.clk_in(clk), .rst_n_in(rst_n), .tick_in(tick), .load_in(load),
        .load_addr_in(loadaddr), .end_out(iend), .pc_out(pc), .w_out(w), .st_out(st));
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task give_verdict;
        $display("comparisons %0d errors %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            errors++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    task tmo;
        errors++;
        $display("BAD handshake exp answer got timeout");
        give_verdict;
    endtask
    // write and read hold each channel until its own ready edge
    task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic ta, tw, tb;
        logic [1:0] r;
        int i;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awv <= 1;
        wv <= 1;
        bready <= 1;
        tb = 0;
        for (i = 0; i < 40 && !tb; i++) begin
            @(negedge clk);
            ta = awv && awrdy;
            tw = wv && wrdy;
            tb = bvalid;
            r = bresp;
            @(posedge clk);
            if (ta) awv <= 0;
            if (tw) wv <= 0;
        end
        bready <= 0;
        if (!tb) tmo;
        chk("bresp", 32'(er), 32'(r));
    endtask
    task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ta, tr;
        int i;
        @(posedge clk);
        araddr <= a;
        arv <= 1;
        rready <= 1;
        tr = 0;
        for (i = 0; i < 40 && !tr; i++) begin
            @(negedge clk);
            ta = arv && arrdy;
            tr = rvalid;
            d = rdata;
            r = rresp;
            @(posedge clk);
            if (ta) arv <= 0;
        end
        rready <= 0;
        if (!tr) tmo;
    endtask
    task rc(input string nm, input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0] r;
        rd(a, d, r);
        chk(nm, e, d);
    endtask
    // pc still holds the entry value while flush stands
    task wflush(input logic exp);
        logic seen;
        int i;
        seen = 0;
        for (i = 0; i < 24 && !seen; i++) begin
            @(negedge clk);
            seen = flush;
            p1 = pc;
        end
        chk("entry", 32'(exp), 32'(seen));
    endtask
    task do_ret;
        ret <= 1;
        @(posedge clk);
        ret <= 0;
        @(negedge clk);
        chk("gie after return", 1, 32'(global_irq_enable));
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task sc_entry;
        wr(ADDR_IRQ_MASK, 32'h1, RESP_OKAY);
        tmr <= 1;
        @(posedge clk);
        tmr <= 0;
        rc("timer flag", ADDR_CORE_CTRL, 32'h04);
        wflush(0);
        wr(ADDR_CORE_CTRL, 32'ha4, RESP_OKAY);
        wflush(1);
        chk("gie at entry", 0, 32'(global_irq_enable));
        rc("shadow w", ADDR_SH_W, {24'h0, p1[7:0] ^ 8'h5a});
        rc("shadow status", ADDR_SH_STATUS, {24'h0, 8'hff & STATUS_SAVE_MASK});
        @(negedge clk);
        chk("irq", 1, 32'(irq));
        wr(ADDR_IRQ_STAT, 32'h1, RESP_OKAY);
        @(negedge clk);
        chk("irq cleared", 0, 32'(irq));
        wr(ADDR_CORE_CTRL, 32'h20, RESP_OKAY);
        do_ret;
        wflush(0);
    endtask
    task sc_periph;
        wr(ADDR_PEN_4, 32'h80, RESP_OKAY);
        wr(ADDR_CORE_CTRL, 32'h80, RESP_OKAY);
        pev <= 32'h8000_0000;
        @(posedge clk);
        pev <= 0;
        rc("periph flag 4", ADDR_PFLAG_4, 32'h80);
        wflush(0);
        wr(ADDR_CORE_CTRL, 32'hc0, RESP_OKAY);
        wflush(1);
        wr(ADDR_PFLAG_4, 32'h0, RESP_OKAY);
        do_ret;
        pchg <= 8'h10;
        rc("change summary", ADDR_CORE_CTRL, 32'hc1);
        wr(ADDR_CORE_CTRL, 32'hc0, RESP_OKAY);
        rc("summary read only", ADDR_CORE_CTRL, 32'hc1);
        pchg <= 8'h00;
        rc("summary clears", ADDR_CORE_CTRL, 32'hc0);
    endtask
    // wrong edge first, then the selected one
    task sc_ext;
        int s;
        for (s = 0; s < 2; s++) begin
            pin <= s[0];
            wr(ADDR_CORE_CTRL, 32'h00, RESP_OKAY);
            wr(ADDR_OPTION, 32'(s), RESP_OKAY);
            pin <= !s[0];
            rc("wrong edge", ADDR_CORE_CTRL, 32'h00);
            pin <= s[0];
            rc("pin flag", ADDR_CORE_CTRL, 32'h02);
        end
        wr(ADDR_CORE_CTRL, 32'h92, RESP_OKAY);
        wflush(1);
        wr(ADDR_CORE_CTRL, 32'h10, RESP_OKAY);
        do_ret;
    endtask
    task sc_wake_bus;
        logic [31:0] d;
        logic [1:0] r;
        sleep <= 1;
        wr(ADDR_CORE_CTRL, 32'h20, RESP_OKAY);
        tmr <= 1;
        @(posedge clk);
        tmr <= 0;
        repeat (2) @(negedge clk);
        chk("wake", 1, 32'(wake));
        sleep <= 0;
        wflush(0);
        rd(8'h4c, d, r);
        chk("unmapped resp", 32'(RESP_SLVERR), 32'(r));
        chk("unmapped data", 0, d);
        wr(ADDR_SEQ_STAT, 32'h1, RESP_SLVERR);
        wr(ADDR_CORE_CTRL, 32'hf8, RESP_OKAY);
        rst_n <= 0;
        repeat (5) @(posedge clk);
        rst_n <= 1;
        @(posedge clk);
        rc("ctrl after reset", ADDR_CORE_CTRL, 32'(CTRL_RESET));
        rc("enable 4 after reset", ADDR_PEN_4, 32'h0);
    endtask
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1;
        @(posedge clk);
        rc("ctrl reset", ADDR_CORE_CTRL, 32'(CTRL_RESET));
        chk("gie reset", 0, 32'(global_irq_enable));
        sc_entry;
        sc_periph;
        sc_ext;
        sc_wake_bus;
        give_verdict;
    end
endmodule
`default_nettype wire
